// [design/scg_pkg.sv]
package scg_pkg;
    localparam int ADDR_W = 12;
    localparam int N_UNITS = 10;

    localparam logic [11:0] RUN_GATE_OFS = 12'h108;
    localparam logic [11:0] SLEEP_GATE_OFS = 12'h118;
    localparam logic [11:0] DEEP_GATE_OFS = 12'h128;
    localparam logic [11:0] RUN_CFG_OFS = 12'h060;
    localparam logic [11:0] FAULT_STAT_OFS = 12'h130;
    localparam logic [11:0] FAULT_MASK_OFS = 12'h134;

    localparam int PHY_BIT = 30;
    localparam int MAC_BIT = 28;
    localparam int PORT_MSB = 7;
    localparam int PORT_LSB = 0;
    localparam int AUTO_GATE_BIT = 0;

    localparam logic [31:0] GATE_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] FAULT_RESET = 32'h0000_0000;
    localparam logic [31:0] GATE_WMASK = 32'h5000_00ff;
    localparam logic [31:0] CFG_WMASK = 32'h0000_0001;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {OP_RUN, OP_SLEEP, OP_DEEP} scg_op_t;

    // Gate word to unit vector {phy, mac, port h..a}
    function automatic logic [N_UNITS-1:0] scg_units(
        input logic [31:0] w);
        return {w[PHY_BIT], w[MAC_BIT], w[PORT_MSB:PORT_LSB]};
    endfunction

    function automatic logic [31:0] scg_word(
        input logic [N_UNITS-1:0] u);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[PHY_BIT] = u[9];
        w[MAC_BIT] = u[8];
        w[PORT_MSB:PORT_LSB] = u[7:0];
        return w;
    endfunction

    // Byte-lane merge limited to writable bits
    function automatic logic [31:0] scg_merge(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb,
        input logic [31:0] wmask);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return r & wmask;
    endfunction
endpackage

// [design/scg_axil_slave.sv]
`timescale 1ns/1ps
module scg_axil_slave #(
    parameter int AW = scg_pkg::ADDR_W
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [AW-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic rd_en,
    output logic [AW-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    import scg_pkg::*;

    logic aw_held, next_aw_held, w_held, next_w_held;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata, next_wr_data;
    logic [AW-1:0] next_wr_addr;
    logic [3:0] next_wr_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_en = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_en = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_wr_data = s_axi_wdata;
            next_wr_strb = s_axi_wstrb;
        end
        if (wr_en) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rd_en) begin
            next_rvalid = 1'b1;
            next_rdata = rd_data;
            next_rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end
endmodule // scg_axil_slave

// [design/scg_gate_bank.sv]
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - A set enable bit keeps its unit clocked while sleep gating applies.
// - A clear enable bit stops that unit's clock while it stays clear.
// - Access to a unit whose clock is off is answered with a fault.
// - Reset clears every gating bit, so all units start unclocked.
// - Run, sleep and deep-sleep states each pick their own gating register.
// - Sleep and deep-sleep gating apply only with auto clock gating set.
// - Bit 30 enables the Ethernet PHY unit clock.
// - Bit 28 enables the Ethernet MAC unit clock.
// - Bits 7 to 0 enable port H down to port A.
// - Bits 31, 29, 27:8 read zero; software preserves them.
// - The sleep gating register decodes at offset 0x118.
module scg_gate_bank #(
    parameter int AW = scg_pkg::ADDR_W
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_mode,
    input wire logic deep_sleep_mode,
    input wire logic [scg_pkg::N_UNITS-1:0] unit_access_req,
    output logic [scg_pkg::N_UNITS-1:0] unit_clock_enable,
    output logic [scg_pkg::N_UNITS-1:0] unit_access_fault,
    output logic irq
);
    import scg_pkg::*;

    logic wr_en, rd_en, wr_err, rd_err;
    logic [AW-1:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;

    logic [31:0] run_clock_gate_2, next_run_clock_gate_2;
    logic [31:0] sleep_clock_gate_2, next_sleep_clock_gate_2;
    logic [31:0] deep_sleep_clock_gate_2, next_deep_sleep_clock_gate_2;
    logic [31:0] run_clock_config, next_run_clock_config;
    logic [31:0] fault_status, next_fault_status;
    logic [31:0] fault_mask, next_fault_mask;
    logic [31:0] sel_gate, fault_clear;
    logic [N_UNITS-1:0] next_clock_enable, fault_hit;
    scg_op_t op_state, next_op_state;
    logic auto_clock_gating;

    scg_axil_slave #(.AW(AW)) u_bus (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    function automatic logic [11:0] word_addr(input logic [AW-1:0] a);
        return {a[11:2], 2'b00};
    endfunction

    assign auto_clock_gating = run_clock_config[AUTO_GATE_BIT];

    // Operating state
    always_comb begin
        if (deep_sleep_mode) begin
            next_op_state = OP_DEEP;
        end else if (sleep_mode) begin
            next_op_state = OP_SLEEP;
        end else begin
            next_op_state = OP_RUN;
        end
    end

    // Gating source; without auto gating the run register stays in charge
    always_comb begin
        sel_gate = run_clock_gate_2;
        unique case (op_state)
            OP_RUN: sel_gate = run_clock_gate_2;
            OP_SLEEP: sel_gate = auto_clock_gating ? sleep_clock_gate_2
                : run_clock_gate_2;
            OP_DEEP: sel_gate = auto_clock_gating ? deep_sleep_clock_gate_2
                : run_clock_gate_2;
            default: sel_gate = run_clock_gate_2;
        endcase
        next_clock_enable = scg_units(sel_gate);
        fault_hit = unit_access_req & ~unit_clock_enable;
    end

    // Register writes
    always_comb begin
        next_run_clock_gate_2 = run_clock_gate_2;
        next_sleep_clock_gate_2 = sleep_clock_gate_2;
        next_deep_sleep_clock_gate_2 = deep_sleep_clock_gate_2;
        next_run_clock_config = run_clock_config;
        next_fault_mask = fault_mask;
        fault_clear = 32'h0000_0000;
        wr_err = 1'b0;
        if (wr_en) begin
            unique case (word_addr(wr_addr))
                RUN_GATE_OFS: next_run_clock_gate_2 = scg_merge(
                    run_clock_gate_2, wr_data, wr_strb, GATE_WMASK);
                SLEEP_GATE_OFS: next_sleep_clock_gate_2 = scg_merge(
                    sleep_clock_gate_2, wr_data, wr_strb,
                    GATE_WMASK);
                DEEP_GATE_OFS: next_deep_sleep_clock_gate_2 = scg_merge(
                    deep_sleep_clock_gate_2, wr_data, wr_strb, GATE_WMASK);
                RUN_CFG_OFS: next_run_clock_config = scg_merge(
                    run_clock_config, wr_data, wr_strb, CFG_WMASK);
                FAULT_MASK_OFS: next_fault_mask = scg_merge(
                    fault_mask, wr_data, wr_strb, GATE_WMASK);
                FAULT_STAT_OFS: fault_clear = scg_merge(
                    32'h0000_0000, wr_data, wr_strb, GATE_WMASK);
                default: wr_err = 1'b1;
            endcase
        end
        // A new fault wins over a clear in the same cycle
        next_fault_status = (fault_status & ~fault_clear)
            | scg_word(fault_hit);
    end

    // Register reads
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        unique case (word_addr(rd_addr))
            RUN_GATE_OFS: rd_data = run_clock_gate_2;
            SLEEP_GATE_OFS: rd_data = sleep_clock_gate_2;
            DEEP_GATE_OFS: rd_data = deep_sleep_clock_gate_2;
            RUN_CFG_OFS: rd_data = run_clock_config;
            FAULT_STAT_OFS: rd_data = fault_status;
            FAULT_MASK_OFS: rd_data = fault_mask;
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            run_clock_gate_2 <= GATE_RESET;
            sleep_clock_gate_2 <= GATE_RESET;
            deep_sleep_clock_gate_2 <= GATE_RESET;
            run_clock_config <= CFG_RESET;
            fault_status <= FAULT_RESET;
            fault_mask <= FAULT_RESET;
            op_state <= OP_RUN;
            unit_clock_enable <= '0;
            unit_access_fault <= '0;
        end else begin
            run_clock_gate_2 <= next_run_clock_gate_2;
            sleep_clock_gate_2 <= next_sleep_clock_gate_2;
            deep_sleep_clock_gate_2 <= next_deep_sleep_clock_gate_2;
            run_clock_config <= next_run_clock_config;
            fault_status <= next_fault_status;
            fault_mask <= next_fault_mask;
            op_state <= next_op_state;
            unit_clock_enable <= next_clock_enable;
            unit_access_fault <= fault_hit;
        end
    end

    assign irq = |(fault_status & fault_mask);

    logic sleep_gated;
    logic sleep_wr;
    assign sleep_gated = op_state == OP_SLEEP && auto_clock_gating;
    assign sleep_wr = wr_en && word_addr(wr_addr) == SLEEP_GATE_OFS;

    sequence s_sleep_gated;
        sleep_gated ##1 sleep_gated;
    endsequence

    property p_keep_on;
        @(posedge mclk) disable iff (sys_rst)
        s_sleep_gated |-> ((scg_units($past(sleep_clock_gate_2))
            & ~unit_clock_enable) == '0);
    endproperty
    a_keep_on: assert property (p_keep_on)
        else $error("sleep enable bit did not keep unit clocked");

    property p_stop;
        @(posedge mclk) disable iff (sys_rst)
        sleep_gated |=> ((unit_clock_enable
            & ~scg_units($past(sleep_clock_gate_2))) == '0);
    endproperty
    a_stop: assert property (p_stop)
        else $error("cleared sleep enable bit left unit clocked");

    property p_fault;
        @(posedge mclk) disable iff (sys_rst)
        (fault_hit != '0) |=> unit_access_fault == $past(fault_hit)
            && (fault_status & scg_word($past(fault_hit)))
            == scg_word($past(fault_hit));
    endproperty
    a_fault: assert property (p_fault)
        else $error("access to gated unit not faulted");

    property p_no_fault;
        @(posedge mclk) disable iff (sys_rst)
        (unit_access_req & ~unit_clock_enable) == '0
            |=> unit_access_fault == '0;
    endproperty
    a_no_fault: assert property (p_no_fault)
        else $error("fault raised for clocked unit");

    property p_reset;
        @(posedge mclk) disable iff (1'b0)
        sys_rst |-> sleep_clock_gate_2 == GATE_RESET
            && unit_clock_enable == '0;
    endproperty
    a_reset: assert property (p_reset)
        else $error("gating not cleared under reset");

    property p_run_src;
        @(posedge mclk) disable iff (sys_rst)
        op_state == OP_RUN |=>
            unit_clock_enable == scg_units($past(run_clock_gate_2));
    endproperty
    a_run_src: assert property (p_run_src)
        else $error("run state not using run gating");

    property p_deep_src;
        @(posedge mclk) disable iff (sys_rst)
        op_state == OP_DEEP && auto_clock_gating |=> unit_clock_enable
            == scg_units($past(deep_sleep_clock_gate_2));
    endproperty
    a_deep_src: assert property (p_deep_src)
        else $error("deep sleep not using deep gating");

    property p_no_auto;
        @(posedge mclk) disable iff (sys_rst)
        op_state != OP_RUN && !auto_clock_gating |=>
            unit_clock_enable == scg_units($past(run_clock_gate_2));
    endproperty
    a_no_auto: assert property (p_no_auto)
        else $error("sleep gating applied without auto gating");

    property p_phy_bit;
        @(posedge mclk) disable iff (sys_rst)
        sleep_wr && wr_strb[3] |=>
            sleep_clock_gate_2[30] == $past(wr_data[30]);
    endproperty
    a_phy_bit: assert property (p_phy_bit)
        else $error("phy enable bit not written");

    property p_mac_bit;
        @(posedge mclk) disable iff (sys_rst)
        sleep_wr && wr_strb[3] |=>
            sleep_clock_gate_2[28] == $past(wr_data[28]);
    endproperty
    a_mac_bit: assert property (p_mac_bit)
        else $error("mac enable bit not written");

    property p_port_bits;
        @(posedge mclk) disable iff (sys_rst)
        sleep_wr && wr_strb[0] |=>
            sleep_clock_gate_2[7:0] == $past(wr_data[7:0]);
    endproperty
    a_port_bits: assert property (p_port_bits)
        else $error("port enable bits not written");

    property p_reserved;
        @(posedge mclk) disable iff (sys_rst)
        (sleep_clock_gate_2 & 32'hafff_ff00) == 32'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved sleep gating bit not zero");

    property p_decode;
        @(posedge mclk) disable iff (sys_rst)
        rd_en && word_addr(rd_addr) == SLEEP_GATE_OFS |=>
            s_axi_rvalid && s_axi_rdata == $past(sleep_clock_gate_2)
            && s_axi_rresp == RESP_OKAY;
    endproperty
    a_decode: assert property (p_decode)
        else $error("sleep gating read at 0x118 wrong");

    property p_write_hold;
        @(posedge mclk) disable iff (sys_rst)
        sleep_wr && op_state == OP_RUN |=>
            unit_clock_enable == scg_units($past(run_clock_gate_2));
    endproperty
    a_write_hold: assert property (p_write_hold)
        else $error("sleep gating write acted while running");
endmodule // scg_gate_bank

// [bench/scg_gate_bank_bench.sv]
`timescale 1ns/1ps
module scg_gate_bank_bench;
    import scg_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic sleep_mode = 1'b0;
    logic deep_sleep_mode = 1'b0;
    logic [9:0] unit_access_req = 10'h000;
    logic [9:0] unit_clock_enable;
    logic [9:0] unit_access_fault;
    logic irq;
    int failures = 0;
    int checks_done = 0;

    scg_gate_bank dut_u (
        .mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sleep_mode, .deep_sleep_mode,
        .unit_access_req, .unit_clock_enable, .unit_access_fault, .irq
    );

    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // Unit vector {phy, mac, port h..a} from a gate word
    function automatic logic [9:0] units_of(input logic [31:0] w);
        return {w[30], w[28], w[7:0]};
    endfunction

    task automatic close_out();
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp_word(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_units(input string nm, input logic [9:0] e,
        input logic [9:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        logic t_aw, t_w, t_b;
        logic [1:0] r;
        int n;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        t_b = 1'b0;
        // Ready is a function of registers, so negedge shows the edge value
        for (n = 0; n < 40 && !t_b; n++) begin
            @(negedge mclk);
            t_aw = s_axi_awvalid && s_axi_awready;
            t_w = s_axi_wvalid && s_axi_wready;
            t_b = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge mclk);
            if (t_aw) s_axi_awvalid <= 1'b0;
            if (t_w) s_axi_wvalid <= 1'b0;
            if (t_b) s_axi_bready <= 1'b0;
        end
        if (!t_b) begin
            failures++;
            close_out();
        end
        cmp_word("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        logic t_ar, t_r;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        t_r = 1'b0;
        for (n = 0; n < 40 && !t_r; n++) begin
            @(negedge mclk);
            t_ar = s_axi_arvalid && s_axi_arready;
            t_r = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge mclk);
            if (t_ar) s_axi_arvalid <= 1'b0;
            if (t_r) s_axi_rready <= 1'b0;
        end
        if (!t_r) begin
            failures++;
            close_out();
        end
        cmp_word("rresp", {30'h0, er}, {30'h0, r});
        cmp_word("rdata", ed, d);
    endtask

    task automatic chk_en(input logic [31:0] w);
        @(negedge mclk);
        cmp_units("unit_clock_enable", units_of(w), unit_clock_enable);
    endtask

    // Operating state takes two edges to reach the enables
    task automatic mode(input logic s, input logic d, input logic [31:0] w);
        @(posedge mclk);
        sleep_mode <= s;
        deep_sleep_mode <= d;
        repeat (2) @(posedge mclk);
        chk_en(w);
    endtask

    task automatic poke(input logic [9:0] v, input logic [9:0] ef);
        @(posedge mclk);
        unit_access_req <= v;
        @(posedge mclk);
        unit_access_req <= 10'h000;
        @(negedge mclk);
        cmp_units("unit_access_fault", ef, unit_access_fault);
        @(negedge mclk);
        cmp_units("unit_access_fault", 10'h000, unit_access_fault);
    endtask

    task automatic t_reset();
        chk_en(32'h0000_0000);
        cmp_bit("irq", 1'b0, irq);
        rd(SLEEP_GATE_OFS, 32'h0000_0000, RESP_OKAY);
        rd(RUN_GATE_OFS, 32'h0000_0000, RESP_OKAY);
        rd(DEEP_GATE_OFS, 32'h0000_0000, RESP_OKAY);
        rd(RUN_CFG_OFS, 32'h0000_0000, RESP_OKAY);
        rd(FAULT_STAT_OFS, 32'h0000_0000, RESP_OKAY);
        rd(FAULT_MASK_OFS, 32'h0000_0000, RESP_OKAY);
        rd(12'h200, 32'h0000_0000, RESP_SLVERR);
        wr(12'h200, 32'hffff_ffff, 4'hf, RESP_SLVERR);
    endtask

    task automatic t_regs();
        wr(SLEEP_GATE_OFS, 32'hffff_ffff, 4'hf, RESP_OKAY);
        rd(SLEEP_GATE_OFS, 32'h5000_00ff, RESP_OKAY);
        wr(SLEEP_GATE_OFS, 32'h0000_0000, 4'h1, RESP_OKAY);
        rd(SLEEP_GATE_OFS, 32'h5000_0000, RESP_OKAY);
        chk_en(32'h0000_0000);
    endtask

    task automatic t_gating();
        logic [31:0] w;
        wr(RUN_GATE_OFS, 32'h1000_0003, 4'hf, RESP_OKAY);
        chk_en(32'h1000_0003);
        wr(SLEEP_GATE_OFS, 32'h4000_00a5, 4'hf, RESP_OKAY);
        chk_en(32'h1000_0003);
        mode(1'b1, 1'b0, 32'h1000_0003);
        wr(RUN_CFG_OFS, 32'h0000_0001, 4'hf, RESP_OKAY);
        chk_en(32'h4000_00a5);
        for (int i = 0; i < 10; i++) begin
            w = (i == 9) ? 32'h4000_0000 : (i == 8) ? 32'h1000_0000
                : (32'h1 << i);
            wr(SLEEP_GATE_OFS, w, 4'hf, RESP_OKAY);
            @(negedge mclk);
            cmp_units("unit_clock_enable", 10'h001 << i,
                unit_clock_enable);
        end
        wr(DEEP_GATE_OFS, 32'h0000_0080, 4'hf, RESP_OKAY);
        mode(1'b1, 1'b1, 32'h0000_0080);
    endtask

    task automatic t_fault();
        poke(10'h3ff, 10'h37f);
        rd(FAULT_STAT_OFS, 32'h5000_007f, RESP_OKAY);
        cmp_bit("irq", 1'b0, irq);
        wr(FAULT_MASK_OFS, 32'h0000_0001, 4'hf, RESP_OKAY);
        @(negedge mclk);
        cmp_bit("irq", 1'b1, irq);
        wr(FAULT_STAT_OFS, 32'h0000_0001, 4'hf, RESP_OKAY);
        @(negedge mclk);
        cmp_bit("irq", 1'b0, irq);
        rd(FAULT_STAT_OFS, 32'h5000_007e, RESP_OKAY);
        mode(1'b0, 1'b0, 32'h1000_0003);
        poke(10'h3ff, 10'h2fc);
    endtask

    // Reset again with the bus idle and the gating registers loaded
    task automatic t_rereset();
        wr(SLEEP_GATE_OFS, 32'h1000_0001, 4'hf, RESP_OKAY);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        chk_en(32'h0000_0000);
        rd(SLEEP_GATE_OFS, 32'h0000_0000, RESP_OKAY);
        rd(RUN_GATE_OFS, 32'h0000_0000, RESP_OKAY);
    endtask

    initial begin
        // Raise reset as an edge so the asynchronous branch runs at once
        sys_rst <= 1'b1;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_regs();
        t_gating();
        t_fault();
        t_rereset();
        close_out();
    end
endmodule // scg_gate_bank_bench
